// file: seru_pkg.sv
// shared constants and field layouts of the four-mode serial port
package seru_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] OFF_CTRL_HIGH = 8'h04;
  localparam logic [7:0] OFF_CTRL_LOW  = 8'h05;
  localparam logic [7:0] OFF_DATA      = 8'h06;
  localparam logic [7:0] OFF_DIVISOR   = 8'hF5;

  // values after reset
  localparam logic [7:0] RST_CTRL_HIGH = 8'h00;
  localparam logic [7:0] RST_CTRL_LOW  = 8'h00;
  localparam logic [7:0] RST_DIVISOR   = 8'h00;
  localparam logic [7:0] RST_DATA      = 8'h00;

  // operating modes held in the top two bits of the high control register
  localparam logic [1:0] MODE_SYNC    = 2'h0;
  localparam logic [1:0] MODE_ASYNC8  = 2'h1;
  localparam logic [1:0] MODE_FIXED9  = 2'h2;
  localparam logic [1:0] MODE_VAR9    = 2'h3;

  // sixteen sub-bit ticks per bit period
  localparam logic [3:0] SUB_LAST   = 4'hF;
  localparam logic [3:0] SUB_CENTRE = 4'h7;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [3:0] CNT_ZERO   = 4'h0;

  // high control register: mode, multiprocessor, transmit ninth bit, receive side
  typedef struct packed {
    logic [1:0] mode;
    logic       mp_ctrl;
    logic       rx_enable;
    logic       tx_ninth;
    logic       rx_ninth_bit;
    logic       rx_int_en;
    logic       rx_pend;
  } seru_ctrl_high_t;

  // low control register: parity, clock source, transmit side
  typedef struct packed {
    logic       tx_par_auto;
    logic       par_odd;
    logic [1:0] rsvd;
    logic [1:0] clk_sel;
    logic       tx_int_en;
    logic       tx_pend;
  } seru_ctrl_low_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP  = 3'b100
  } seru_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP  = 3'b100
  } seru_rx_state_t;

endpackage

// file: seru_sync3.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ns
`default_nettype none
module seru_sync3 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_i,
  output logic      level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // first stage feeds only the second; level moves once two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r  <= 1'b1;
      s2_r  <= 1'b1;
      s3_r  <= 1'b1;
      level <= 1'b1;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

// file: seru_baud.sv
// uart clock prescaler and baud divisor making the sixteen-per-bit tick
`timescale 1ns/1ns
`default_nettype none
module seru_baud (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] clk_sel,
  input  wire logic       fixed_rate,
  input  wire logic [7:0] divisor,
  output logic            tick
);
  logic [2:0] pre_r;
  logic [7:0] cnt_r;
  logic [2:0] pre_mask;
  logic       fu_en;
  logic [7:0] limit;

  // uart clock is the system clock divided by 1, 2, 4 or 8
  assign pre_mask = (clk_sel == 2'h0) ? 3'h0 :
                    (clk_sel == 2'h1) ? 3'h1 :
                    (clk_sel == 2'h2) ? 3'h3 : 3'h7;
  assign fu_en    = ((pre_r & pre_mask) == pre_mask);
  // fixed mode ignores the divisor: one tick per uart clock
  assign limit    = fixed_rate ? 8'h00 : divisor;
  assign tick     = fu_en && (cnt_r >= limit);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_r <= 3'h0;
      cnt_r <= 8'h00;
    end else begin
      pre_r <= pre_r + 3'h1;
      if (tick) begin
        cnt_r <= 8'h00;
      end else if (fu_en) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_fixed_rate: assert property (
    fixed_rate && fu_en |-> tick)
    else $error("fixed rate mode missed a tick");
  chk_var_rate: assert property (
    !fixed_rate && fu_en && cnt_r < limit && $stable(limit) |-> !tick)
    else $error("tick before divisor count reached");
endmodule
`default_nettype wire

// file: seru_port.sv
// four-mode serial port: registers, transmitter and receiver
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module seru_port (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       serial_in_pin_i,
  output logic            serial_in_pin_o,
  output logic            serial_in_pin_oe,
  output logic            serial_out_pin,
  output logic            rx_irq,
  output logic            tx_irq
);
  seru_pkg::seru_ctrl_high_t ctrl_high_r;
  seru_pkg::seru_ctrl_low_t  ctrl_low_r;
  seru_pkg::seru_tx_state_t  tx_state_r;
  seru_pkg::seru_tx_state_t  tx_state_nxt;
  seru_pkg::seru_rx_state_t  rx_state_r;
  seru_pkg::seru_rx_state_t  rx_state_nxt;
  logic [7:0] div_r;
  logic [7:0] tx_shift_r;
  logic [7:0] tx_shift_nxt;
  logic       tx_ninth_r;
  logic [3:0] tx_sub_r;
  logic [3:0] tx_sub_nxt;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_cnt_nxt;
  logic       tx_done;
  logic [7:0] rx_shift_r;
  logic [7:0] rx_shift_nxt;
  logic [7:0] rx_buf_r;
  logic [3:0] rx_sub_r;
  logic [3:0] rx_sub_nxt;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_cnt_nxt;
  logic       rx_done;
  logic       rx_ninth_cap;
  logic       tick;
  logic       rxd;

  // address decode of the register port
  logic wr_high;
  logic wr_low;
  logic wr_data;
  logic wr_div;
  logic is_sync;
  logic is_nine;
  logic tx_busy;
  logic rx_busy;
  logic tx_go;
  logic sync_rx_go;
  logic async_rx_go;
  logic samp;
  logic tx_line;
  logic tx_ninth_val;
  logic [7:0] rd_val;

  assign wr_high = reg_wr && (reg_addr == seru_pkg::OFF_CTRL_HIGH);
  assign wr_low  = reg_wr && (reg_addr == seru_pkg::OFF_CTRL_LOW);
  assign wr_data = reg_wr && (reg_addr == seru_pkg::OFF_DATA);
  assign wr_div  = reg_wr && (reg_addr == seru_pkg::OFF_DIVISOR);

  // mode decode; only 00 is the shift mode, the top bit marks nine bits
  assign is_sync = (ctrl_high_r.mode == seru_pkg::MODE_SYNC);
  assign is_nine = ctrl_high_r.mode[1];
  assign tx_busy = (tx_state_r != seru_pkg::TX_IDLE);
  assign rx_busy = (rx_state_r != seru_pkg::RX_IDLE);

  // shift mode shares one data pin, so transmit and receive exclude each other
  assign tx_go       = wr_data && !tx_busy &&
                       !(is_sync && rx_busy);
  assign sync_rx_go  = is_sync && ctrl_high_r.rx_enable &&
                       !ctrl_high_r.rx_pend && !tx_busy && !wr_data;
  assign async_rx_go = !is_sync && ctrl_high_r.rx_enable && !rxd;

  // shift mode samples at the end of the low clock half, async at bit centre
  assign samp = tick && (rx_sub_r == (is_sync ? seru_pkg::SUB_CENTRE
                                              : seru_pkg::SUB_LAST));

  // ninth bit is either software's bit or generated parity
  assign tx_ninth_val = ctrl_low_r.tx_par_auto ?
                        (^reg_wdata) ^ ctrl_low_r.par_odd :
                        ctrl_high_r.tx_ninth;

  // line level of the async transmitter per state
  assign tx_line = (tx_state_r == seru_pkg::TX_START) ? 1'b0 :
                   (tx_state_r == seru_pkg::TX_DATA)  ? tx_shift_r[0] :
                   (tx_state_r == seru_pkg::TX_NINTH) ? tx_ninth_r :
                   1'b1;

  // separate buffers: a data read never sees what was written
  assign rd_val = (reg_addr == seru_pkg::OFF_CTRL_HIGH) ? ctrl_high_r :
                  (reg_addr == seru_pkg::OFF_CTRL_LOW)  ?
                    {ctrl_low_r[7:6], 2'h0, ctrl_low_r[3:0]} :
                  (reg_addr == seru_pkg::OFF_DATA)      ? rx_buf_r :
                  (reg_addr == seru_pkg::OFF_DIVISOR)   ? div_r : 8'h00;

  // transmitter sequencing
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_shift_nxt = tx_shift_r;
    tx_sub_nxt   = tx_sub_r;
    tx_cnt_nxt   = tx_cnt_r;
    tx_done      = 1'b0;
    if (tx_go) begin
      tx_shift_nxt = reg_wdata;
      tx_sub_nxt   = seru_pkg::CNT_ZERO;
      tx_cnt_nxt   = seru_pkg::CNT_ZERO;
      tx_state_nxt = is_sync ? seru_pkg::TX_DATA : seru_pkg::TX_START;
    end else if (tick && tx_busy) begin
      tx_sub_nxt = tx_sub_r + 4'h1;
      if (tx_sub_r == seru_pkg::SUB_LAST) begin
        case (tx_state_r)
          seru_pkg::TX_START: begin
            tx_state_nxt = seru_pkg::TX_DATA;
          end
          seru_pkg::TX_DATA: begin
            tx_shift_nxt = {1'b1, tx_shift_r[7:1]};
            tx_cnt_nxt   = tx_cnt_r + 4'h1;
            if (tx_cnt_r == seru_pkg::LAST_BIT) begin
              if (is_sync) begin
                tx_state_nxt = seru_pkg::TX_IDLE;
                tx_done      = 1'b1;
              end else if (is_nine) begin
                tx_state_nxt = seru_pkg::TX_NINTH;
              end else begin
                tx_state_nxt = seru_pkg::TX_STOP;
                tx_done      = 1'b1;
              end
            end
          end
          seru_pkg::TX_NINTH: begin
            tx_state_nxt = seru_pkg::TX_STOP;
            tx_done      = 1'b1;
          end
          default: begin
            tx_state_nxt = seru_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // receiver sequencing
  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_shift_nxt = rx_shift_r;
    rx_sub_nxt   = rx_sub_r;
    rx_cnt_nxt   = rx_cnt_r;
    rx_done      = 1'b0;
    rx_ninth_cap = 1'b0;
    case (rx_state_r)
      seru_pkg::RX_IDLE: begin
        rx_sub_nxt = seru_pkg::CNT_ZERO;
        rx_cnt_nxt = seru_pkg::CNT_ZERO;
        if (sync_rx_go) begin
          rx_state_nxt = seru_pkg::RX_DATA;
        end else if (async_rx_go) begin
          rx_state_nxt = seru_pkg::RX_START;
        end
      end
      seru_pkg::RX_START: begin
        if (tick) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
          // a glitch shorter than half a bit is dropped
          if (rx_sub_r == seru_pkg::SUB_CENTRE) begin
            rx_sub_nxt   = seru_pkg::CNT_ZERO;
            rx_state_nxt = rxd ? seru_pkg::RX_IDLE : seru_pkg::RX_DATA;
          end
        end
      end
      seru_pkg::RX_DATA: begin
        if (tick) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
        end
        if (samp) begin
          rx_shift_nxt = {rxd, rx_shift_r[7:1]};
          rx_cnt_nxt   = rx_cnt_r + 4'h1;
          if (rx_cnt_r == seru_pkg::LAST_BIT) begin
            if (is_sync) begin
              rx_state_nxt = seru_pkg::RX_IDLE;
              rx_done      = 1'b1;
            end else begin
              rx_state_nxt = is_nine ? seru_pkg::RX_NINTH
                                     : seru_pkg::RX_STOP;
            end
          end
        end
      end
      seru_pkg::RX_NINTH: begin
        if (tick) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
        end
        if (samp) begin
          rx_ninth_cap = 1'b1;
          rx_done      = 1'b1;
          rx_state_nxt = seru_pkg::RX_STOP;
        end
      end
      seru_pkg::RX_STOP: begin
        if (tick) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
        end
        if (samp) begin
          rx_done      = !is_nine;
          rx_state_nxt = seru_pkg::RX_IDLE;
        end
      end
      default: begin
        rx_state_nxt = seru_pkg::RX_IDLE;
      end
    endcase
  end

  // shift state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_state_r <= seru_pkg::TX_IDLE;
      rx_state_r <= seru_pkg::RX_IDLE;
      tx_shift_r <= seru_pkg::RST_DATA;
      rx_shift_r <= seru_pkg::RST_DATA;
      tx_sub_r   <= seru_pkg::CNT_ZERO;
      rx_sub_r   <= seru_pkg::CNT_ZERO;
      tx_cnt_r   <= seru_pkg::CNT_ZERO;
      rx_cnt_r   <= seru_pkg::CNT_ZERO;
      tx_ninth_r <= 1'b1;
    end else begin
      tx_state_r <= tx_state_nxt;
      rx_state_r <= rx_state_nxt;
      tx_shift_r <= tx_shift_nxt;
      rx_shift_r <= rx_shift_nxt;
      tx_sub_r   <= tx_sub_nxt;
      rx_sub_r   <= rx_sub_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      if (tx_go) begin
        tx_ninth_r <= tx_ninth_val;
      end
    end
  end

  // register file; hardware set of a pending flag beats a software clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_high_r <= seru_pkg::RST_CTRL_HIGH;
      ctrl_low_r  <= seru_pkg::RST_CTRL_LOW;
      div_r       <= seru_pkg::RST_DIVISOR;
      rx_buf_r    <= seru_pkg::RST_DATA;
    end else begin
      if (wr_high) begin
        ctrl_high_r <= reg_wdata;
      end
      if (wr_low) begin
        ctrl_low_r <= {reg_wdata[7:6], 2'h0, reg_wdata[3:0]};
      end
      if (rx_ninth_cap) begin
        ctrl_high_r.rx_ninth_bit <= rxd;
      end
      // software alone clears the flags; acknowledging does not
      if (rx_done) begin
        ctrl_high_r.rx_pend <= 1'b1;
      end
      if (tx_done) begin
        ctrl_low_r.tx_pend <= 1'b1;
      end
      if (wr_div) begin
        div_r <= reg_wdata;
      end
      // an unread byte is simply overwritten by the newer one
      if (rx_done) begin
        rx_buf_r <= rx_shift_nxt;
      end
    end
  end

  // registered pins, read data and interrupt requests
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata        <= 8'h00;
      serial_out_pin   <= 1'b1;
      serial_in_pin_o  <= 1'b1;
      serial_in_pin_oe <= 1'b0;
      rx_irq           <= 1'b0;
      tx_irq           <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 8'h00;
      // shift clock idles high, low in the first half of each bit
      if (is_sync) begin
        serial_out_pin <= tx_busy ? tx_sub_r[3] :
                          rx_busy ? rx_sub_r[3] : 1'b1;
      end else begin
        serial_out_pin <= tx_line;
      end
      serial_in_pin_o  <= tx_shift_r[0];
      serial_in_pin_oe <= is_sync && tx_busy;
      rx_irq <= ctrl_high_r.rx_pend && ctrl_high_r.rx_int_en;
      tx_irq <= ctrl_low_r.tx_pend && ctrl_low_r.tx_int_en;
    end
  end

  seru_baud u_baud (
    .clk        (clk),
    .rst_n      (rst_n),
    .clk_sel    (ctrl_low_r.clk_sel),
    .fixed_rate (ctrl_high_r.mode == seru_pkg::MODE_FIXED9),
    .divisor    (div_r),
    .tick       (tick)
  );

  seru_sync3 u_rxd_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin_i (serial_in_pin_i),
    .level (rxd)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_tx_start: assert property (
    tx_go |=> tx_busy ##0 tx_shift_r == $past(reg_wdata))
    else $error("data write did not start transmission");
  chk_rx_buf_sep: assert property (
    wr_data && !rx_done |=> $stable(rx_buf_r))
    else $error("data write disturbed receive buffer");
  chk_rx_pend_set: assert property (
    rx_done |=> ctrl_high_r.rx_pend ##1 rx_irq == ctrl_high_r.rx_int_en)
    else $error("receive completion not flagged");
  chk_tx_pend_set: assert property (
    tx_done |=> ctrl_low_r.tx_pend ##1 tx_irq == ctrl_low_r.tx_int_en)
    else $error("transmit completion not flagged");
  chk_sync_rx_go: assert property (
    rx_state_r == seru_pkg::RX_IDLE && sync_rx_go |=>
      rx_state_r == seru_pkg::RX_DATA)
    else $error("synchronous receive did not start");
  chk_async_rx_go: assert property (
    rx_state_r == seru_pkg::RX_IDLE && async_rx_go |=>
      rx_state_r == seru_pkg::RX_START)
    else $error("start bit not detected");
  chk_stop_high: assert property (
    !is_sync && tx_state_r == seru_pkg::TX_STOP && $stable(ctrl_high_r.mode)
      |=> serial_out_pin)
    else $error("stop bit not high");
  chk_start_low: assert property (
    !is_sync && tx_state_r == seru_pkg::TX_START && $stable(ctrl_high_r.mode)
      |=> !serial_out_pin)
    else $error("start bit not low");
  chk_ctrl_reset: assert property (
    $rose(rst_n) |-> ctrl_high_r == 8'h00 && ctrl_low_r == 8'h00)
    else $error("control registers not cleared by reset");
endmodule
`default_nettype wire

// file: seru_remote.sv
// remote serial device: async frame source and sink, shift-register peer
`timescale 1ns/1ns
`default_nettype none
module seru_remote (
  input  wire logic clk,
  input  wire logic line_in,
  input  wire logic wire_in,
  output logic      drive_o
);
  // the peer idles its drive high, so the line reads high while the device releases it
  initial drive_o = 1'b1;

  // start low, data lsb first, optional ninth bit, stop high
  task automatic send_frame(input logic [8:0] d, input logic nine,
                            input int per);
    drive_o <= 1'b0;
    repeat (per) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      drive_o <= d[i];
      repeat (per) @(posedge clk);
    end
    drive_o <= 1'b1;
    repeat (per) @(posedge clk);
  endtask

  // centre-sample a frame from the device, aligned on the start edge
  task automatic get_frame(input logic nine, input int per,
                           output logic [8:0] d, output logic stop_b);
    d = 9'h000;
    @(negedge line_in);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (per) @(posedge clk);
      d[i] = line_in;
    end
    repeat (per) @(posedge clk);
    stop_b = line_in;
  endtask

  // shift peer: new bit on clock fall, capture on clock rise
  task automatic shift8(input logic [7:0] tx_d, output logic [7:0] rx_d);
    rx_d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      @(negedge line_in) drive_o <= tx_d[i];
      @(posedge line_in) rx_d[i] = wire_in;
    end
    @(posedge clk) drive_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: seru_port_test.sv
// self-checking bench for the four-mode serial port
`timescale 1ns/1ns
`default_nettype none
module seru_port_test;
  logic       clk;
  logic       rst_n;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       pin_o;
  logic       pin_oe;
  logic       out_pin;
  logic       rx_irq;
  logic       tx_irq;
  logic       peer_drv;
  wire logic  line_lvl;
  int         bad_count = 0;
  int         total_checks = 0;
  int         seed;
  int         rx_q[$];
  logic [7:0] offs [5] = '{8'h04, 8'h05, 8'h06, 8'hF5, 8'h33};

  // device drives the shared pin only while its enable is high
  assign line_lvl = pin_oe ? pin_o : peer_drv;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  seru_port u_seru_port (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in_pin_i(line_lvl), .serial_in_pin_o(pin_o),
    .serial_in_pin_oe(pin_oe), .serial_out_pin(out_pin),
    .rx_irq(rx_irq), .tx_irq(tx_irq)
  );

  seru_remote u_seru_remote (
    .clk(clk), .line_in(out_pin), .wire_in(line_lvl), .drive_o(peer_drv)
  );

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_frame(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait on an interrupt line; a miss counts as a mismatch
  task automatic wait_irq(input logic rx);
    logic f;
    f = 1'b0;
    for (int i = 0; i < 4000 && f !== 1'b1; i++) begin
      @(posedge clk);
      #1 f = rx ? rx_irq : tx_irq;
    end
    check_reg({7'h00, f}, 8'h01);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // cut a hang short well past the expected run of some 3200 cycles
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] v, d, got, ch, cl, e8;
    logic [8:0] f, e;
    logic       sb, t9, nine, par;
    int         per, x;
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    seed      = 39336;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(offs[i], v);
      check_reg(v, 8'h00);
    end
    wr(8'h05, 8'hFE);
    rd(8'h05, v);
    check_reg(v, 8'hCE);
    wr(8'h04, 8'hFA);
    rd(8'h04, v);
    check_reg(v, 8'hFA);
    wr(8'hF5, 8'h01);
    rd(8'hF5, v);
    check_reg(v, 8'h01);
    // async modes: divisor 1 gives 32 cycles a bit, fixed mode 16
    for (int m = 1; m < 4; m++) begin
      nine = (m != 1);
      par  = (m == 3);
      per  = (m == 2) ? 16 : 32;
      t9   = 1'($random(seed));
      d    = 8'($random(seed));
      cl   = par ? 8'hC2 : 8'h02;
      ch   = {m[1:0], 2'b01, t9, 3'b010};
      wr(8'h05, cl);
      wr(8'h04, ch);
      e = nine ? {par ? ~^d : t9, d} : {1'b0, d};
      fork
        u_seru_remote.get_frame(nine, per, f, sb);
        wr(8'h06, d);
      join
      check_frame(f, e);
      check_frame({8'h00, sb}, 9'h001);
      wait_irq(1'b0);
      rd(8'h05, v);
      check_reg(v, cl | 8'h01);
      wr(8'h05, cl);
      // two frames without a read in between: the newer one stays
      for (int k = 0; k < 2; k++) begin
        rx_q.push_back($random(seed) & 32'h1FF);
        u_seru_remote.send_frame(9'(rx_q[$]), nine, per);
      end
      wait_irq(1'b1);
      x = rx_q[$];
      rd(8'h06, v);
      check_reg(v, 8'(x));
      e8 = ch | 8'h01 | (nine ? {5'h00, x[8], 2'b00} : 8'h00);
      rd(8'h04, v);
      check_reg(v & (nine ? 8'hFF : 8'hFB), e8);
      wr(8'h04, ch);
    end
    // synchronous shift mode, transmit then receive
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h02);
    d = 8'($random(seed));
    fork
      u_seru_remote.shift8(8'hFF, got);
      wr(8'h06, d);
    join
    check_reg(got, d);
    wait_irq(1'b0);
    wr(8'h05, 8'h02);
    d = 8'($random(seed));
    fork
      u_seru_remote.shift8(d, got);
      wr(8'h04, 8'h12);
    join
    wait_irq(1'b1);
    rd(8'h06, v);
    check_reg(v, d);
    wr(8'h04, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
